//--- hw/iiwh_computer.sv
// mainframe end: input instruction decode, cycle sequencing, accumulator and memory write
`timescale 1ns/1ns
`default_nettype none
`include "iiwh_params.svh"
// Summary of operation
// - decode wait bit 9, unit bits 10-15
// - wait flag one selects wait mode
// - skip mode adds one more word when ready returns
// - wait stall blocks all but power/stall interrupts
// - merge zero loads full accumulator word
// - merge one ORs low byte into 8-15
// - memory form two words, indirect bit 5
// - indirect zero: second word is target
// - indirect: fifteenth address bit from map bit and PC bit 15
// - two instruction cycles plus one execute
// - execute only after address and sync reply
// - transfer enable held whole instruction
// - sync level raised at phase T4
// - unit latch sets on T2/T8 when ready
// - sync reply releases mainframe hold latch
// - skip mode not ready: sync without ready
// - wait mode: stay until replies arrive
// - sync removal clears unit replies
// - ready reply drives input word on bus
// - word accepted clears drive and sync
// - accumulator form single word, memory both modes
// - enable and input levels active low
// - skip mode sync on first gated pulse
module iiwh_computer import iiwh_pkg::*; (
	input wire logic ref_clk, // system clock
	input wire logic reset_n, // sync reset, low active
	input wire logic start, // one-cycle instruction start
	input wire logic isMemForm, // memory form when high
	input wire logic [15:0] instrWord, // first instruction word
	input wire logic [15:0] pcIn, // program counter at first word
	input wire logic [15:0] memRdata, // second/address word from memory
	input wire logic [15:0] accIn, // present accumulator
	input wire logic intReq, // ordinary interrupt request
	input wire logic pfIntReq, // power fail / stall alarm request
	output logic memRd, // read request for memRdAddr
	output logic [15:0] memRdAddr, // memory read address
	output logic memWr, // write input word to memory
	output logic [14:0] memWrAddr, // memory write address
	output logic [15:0] memWdata, // memory write data
	output logic accWr, // accumulator load pulse
	output logic [15:0] accOut, // new accumulator value
	output logic [15:0] pcOut, // next program counter
	output logic done, // instruction complete pulse
	output logic skipped, // ready reply seen
	output logic intAccept, // interrupt taken
	output logic xferEnable_n, // transfer enable, 0 active
	output logic inputDir_n, // input direction, 0 active
	output logic waitFlag, // held wait flag
	output logic [5:0] unitNum, // held unit number
	output logic instrSync, // selection sync level
	output logic timePulse, // T2/T8 timing pulse
	output logic wordAccepted, // word accepted level
	input wire logic testReturn, // ready reply
	input wire logic syncReturn, // sync reply
	input wire logic [15:0] dataBus // input word
);
	iiwh_state_t state_reg, state_next;
	logic [7:0] phase_reg;
	logic [15:0] instr_reg, pc_reg, addr_reg;
	logic memForm_reg, hold_reg, ready_reg, sync_reg, wait_reg, acc_reg;
	logic [3:0] indCnt_reg;
	logic trSync1_reg, trSync2_reg, syncRet1_reg, syncRet2_reg;
	logic [15:0] bus1_reg, bus2_reg, inWord_reg;
	logic [14:0] resolvedAddr;
	logic cycEnd, ph4, phPulse, indirectMore, waitStall, takeInstr;

	// synchronisers for the far end's replies
	always_ff @(posedge ref_clk) begin
		trSync1_reg <= testReturn;
		trSync2_reg <= trSync1_reg;
		syncRet1_reg <= syncReturn;
		syncRet2_reg <= syncRet1_reg;
		bus1_reg <= dataBus;
		bus2_reg <= bus1_reg;
	end

	// memory cycle phase decode, one phase counter for the whole cycle
	assign cycEnd = (phase_reg == 8'(`IIWH_CYCLE_CLKS - 1));
	assign ph4 = (phase_reg == `IIWH_PH_T4);
	assign phPulse = (phase_reg == `IIWH_PH_T2) || (phase_reg == `IIWH_PH_T8);

	// address word: bits 2-15 as 14 low bits plus map-selected top bit
	function automatic logic [14:0] resolve(input logic [15:0] aw, input logic map,
		input logic pcTop);
		resolve = {map & pcTop, aw[`IIWH_ADDR_LSB+13:`IIWH_ADDR_LSB]};
	endfunction : resolve

	assign resolvedAddr = resolve(memRdata, instr_reg[`IIWH_MAP_BIT], pc_reg[15]);
	assign indirectMore = memRdata[`IIWH_AIND_BIT] && (indCnt_reg < `IIWH_MAX_IND);
	assign waitStall = (state_reg == IIWH_TEST) && wait_reg && hold_reg;
	assign takeInstr = (state_reg == IIWH_IDLE) && start;

	// next state at each memory cycle boundary
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			IIWH_IDLE: if (start) state_next = IIWH_FETCH;
			IIWH_FETCH: if (cycEnd) state_next = memForm_reg && instr_reg[`IIWH_IND_BIT] ?
				IIWH_IND : IIWH_TEST;
			IIWH_IND: if (cycEnd && !indirectMore) state_next = IIWH_TEST;
			IIWH_TEST: if (cycEnd && sync_reg && !hold_reg) state_next = IIWH_EXEC;
			IIWH_EXEC: if (cycEnd) state_next = IIWH_IDLE;
			default: state_next = IIWH_IDLE;
		endcase
	end

	// sequencing, sync level and hold latch
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_reg <= IIWH_IDLE;
			phase_reg <= 8'h00;
			hold_reg <= 1'b0;
			sync_reg <= 1'b0;
			ready_reg <= 1'b0;
			indCnt_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			phase_reg <= (state_reg == IIWH_IDLE || cycEnd) ? `IIWH_PH_T1 : phase_reg + 8'h01;
			if (state_reg == IIWH_IDLE) begin
				sync_reg <= 1'b0;
				hold_reg <= 1'b0;
				ready_reg <= 1'b0;
				indCnt_reg <= 4'h0;
			end
			if (state_reg == IIWH_FETCH && ph4) begin
				sync_reg <= 1'b1;
				hold_reg <= 1'b1;
			end
			if (hold_reg && syncRet2_reg) begin
				hold_reg <= 1'b0;
				ready_reg <= trSync2_reg;
			end
			if (state_reg == IIWH_IND && cycEnd) indCnt_reg <= indCnt_reg + 4'h1;
			if (state_reg == IIWH_EXEC && ph4) sync_reg <= 1'b0;
		end
	end

	// instruction register and address resolution
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			instr_reg <= 16'h0000;
			pc_reg <= 16'h0000;
			addr_reg <= 16'h0000;
			memForm_reg <= 1'b0;
			wait_reg <= 1'b0;
		end else if (state_reg == IIWH_IDLE && start) begin
			instr_reg <= instrWord;
			pc_reg <= pcIn;
			memForm_reg <= isMemForm;
			wait_reg <= instrWord[`IIWH_WAIT_BIT];
			addr_reg <= pcIn + 16'h0001;
		end else if (cycEnd && (state_reg == IIWH_FETCH || state_reg == IIWH_IND)) begin
			if (state_reg == IIWH_IND) addr_reg <= {1'b0, resolvedAddr};
			else if (!instr_reg[`IIWH_IND_BIT]) addr_reg <= memRdata;
		end
	end

	// input word latched as word accepted rises; the unit drops its drive right after
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			inWord_reg <= 16'h0000;
		end else if (state_reg == IIWH_EXEC && phase_reg == `IIWH_PH_T1 && ready_reg) begin
			inWord_reg <= bus2_reg;
		end
	end

	// output registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			memRd <= 1'b0;
			memRdAddr <= 16'h0000;
			memWr <= 1'b0;
			memWrAddr <= 15'h0000;
			memWdata <= 16'h0000;
			accWr <= 1'b0;
			accOut <= 16'h0000;
			pcOut <= 16'h0000;
			done <= 1'b0;
			skipped <= 1'b0;
			intAccept <= 1'b0;
			xferEnable_n <= 1'b1;
			inputDir_n <= 1'b1;
			waitFlag <= 1'b0;
			unitNum <= 6'h00;
			instrSync <= 1'b0;
			timePulse <= 1'b0;
			wordAccepted <= 1'b0;
			acc_reg <= 1'b0;
		end else begin
			xferEnable_n <= (state_next == IIWH_IDLE);
			inputDir_n <= (state_next == IIWH_IDLE);
			// fields change in the same cycle as the enable, never after it
			waitFlag <= takeInstr ? instrWord[`IIWH_WAIT_BIT] : wait_reg;
			unitNum <= takeInstr ? instrWord[`IIWH_UNIT_MSB:`IIWH_UNIT_LSB] :
				instr_reg[`IIWH_UNIT_MSB:`IIWH_UNIT_LSB];
			instrSync <= sync_reg;
			timePulse <= phPulse && sync_reg;
			memRd <= (state_reg == IIWH_FETCH || state_reg == IIWH_IND) && ph4;
			memRdAddr <= (state_reg == IIWH_IND) ? addr_reg : pc_reg + 16'h0001;
			// word accepted only after a ready reply, held through execute phases 0-127
			wordAccepted <= (state_reg == IIWH_EXEC) && ready_reg && !phase_reg[7];
			acc_reg <= (state_reg == IIWH_EXEC) && ready_reg && ph4;
			accWr <= acc_reg && !memForm_reg;
			memWr <= acc_reg && memForm_reg;
			memWrAddr <= addr_reg[14:0];
			memWdata <= inWord_reg;
			accOut <= instr_reg[`IIWH_MERGE_BIT] ? {accIn[15:8] | inWord_reg[7:0], accIn[7:0]} :
				inWord_reg;
			done <= (state_reg == IIWH_EXEC) && cycEnd;
			skipped <= ready_reg;
			// skip by one word past the whole instruction when ready
			pcOut <= pc_reg + (memForm_reg ? 16'h0002 : 16'h0001) +
				(ready_reg ? 16'h0001 : 16'h0000);
			intAccept <= waitStall ? pfIntReq : (state_reg == IIWH_IDLE) && (intReq || pfIntReq);
		end
	end
endmodule : iiwh_computer
`default_nettype wire

//--- hw/iiwh_if.sv
// signal bundle between mainframe and peripheral data terminal
`timescale 1ns/1ns
`default_nettype none
interface iiwh_if;
	logic xferEnable;
	logic inputDir;
	logic waitFlag;
	logic [5:0] unitNum;
	logic instrSync;
	logic timePulse;
	logic wordAccepted;
	logic testReturn;
	logic syncReturn;
	logic [15:0] dataBus;
	logic dataBusOe;
	modport computer(output xferEnable, inputDir, waitFlag, unitNum, instrSync, timePulse,
		wordAccepted, input testReturn, syncReturn, dataBus, dataBusOe);
	modport unit(input xferEnable, inputDir, waitFlag, unitNum, instrSync, timePulse,
		wordAccepted, output testReturn, syncReturn, dataBus, dataBusOe);
endinterface : iiwh_if
`default_nettype wire

//--- hw/iiwh_params.svh
// timing and field constants for the input word handshake
`ifndef IIWH_PARAMS_SVH
`define IIWH_PARAMS_SVH
`define IIWH_WAIT_BIT 9
`define IIWH_UNIT_LSB 10
`define IIWH_UNIT_MSB 15
`define IIWH_MERGE_BIT 4
`define IIWH_IND_BIT 5
`define IIWH_MAP_BIT 6
`define IIWH_XFLAG_BIT 1
`define IIWH_AIND_BIT 0
`define IIWH_ADDR_LSB 2
`define IIWH_CYCLE_NS 1750
`define IIWH_CLK_NS 8
`define IIWH_CYCLE_CLKS ((`IIWH_CYCLE_NS + `IIWH_CLK_NS - 1) / `IIWH_CLK_NS)
`define IIWH_PH_T1 8'h00
`define IIWH_PH_T2 8'h1B
`define IIWH_PH_T4 8'h51
`define IIWH_PH_T8 8'hBD
`define IIWH_MAX_IND 4'h7
`endif

//--- hw/iiwh_pkg.sv
// types shared by both ends of the input word handshake
package iiwh_pkg;
	typedef enum logic [2:0] {
		IIWH_IDLE = 3'h0,
		IIWH_FETCH = 3'h1,
		IIWH_IND = 3'h3,
		IIWH_TEST = 3'h2,
		IIWH_EXEC = 3'h6
	} iiwh_state_t;
	typedef logic [15:0] iiwh_word_t;
endpackage : iiwh_pkg

//--- hw/iiwh_unit.sv
// peripheral end: selection, ready and sync reply latches, input word drive
`timescale 1ns/1ns
`default_nettype none
`include "iiwh_params.svh"
module iiwh_unit import iiwh_pkg::*; (
	input wire logic ref_clk, // system clock
	input wire logic reset_n, // sync reset, low active
	input wire logic [5:0] myCode, // this unit's code
	input wire logic bufReady, // input buffer holds a word
	input wire logic [15:0] bufWord, // word to hand over
	output logic wordTaken, // pulse: word accepted by computer
	input wire logic xferEnable_n, // transfer enable, 0 active
	input wire logic inputDir_n, // input direction, 0 active
	input wire logic waitFlag, // wait mode
	input wire logic [5:0] unitNum, // selected unit
	input wire logic instrSync, // selection sync
	input wire logic timePulse, // T2/T8 pulse
	input wire logic wordAccepted, // word accepted level
	output logic testReturn, // ready reply
	output logic syncReturn, // sync reply
	output logic [15:0] dataBus, // input word
	output logic dataBusOe // drives data bus
);
	logic selected, trig, accPrev_reg;
	logic drive_reg;

	assign selected = instrSync && !xferEnable_n && (unitNum == myCode);
	assign trig = selected && timePulse;

	// reply latches follow the selection sync level
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !selected) begin
			testReturn <= 1'b0;
			syncReturn <= 1'b0;
			drive_reg <= 1'b0;
			accPrev_reg <= 1'b0;
			wordTaken <= 1'b0;
		end else begin
			accPrev_reg <= wordAccepted;
			wordTaken <= wordAccepted && !accPrev_reg && drive_reg;
			if (wordAccepted) begin
				syncReturn <= 1'b0;
				drive_reg <= 1'b0;
			end else if (trig && bufReady && !testReturn && !accPrev_reg) begin
				testReturn <= 1'b1;
				syncReturn <= 1'b1;
				drive_reg <= !inputDir_n;
			end else if (trig && !waitFlag) begin
				syncReturn <= 1'b1;
			end
			// wait mode, not ready: keep testing on later pulses
		end
	end

	// bus driven only while the drive level stands
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			dataBus <= 16'h0000;
			dataBusOe <= 1'b0;
		end else begin
			dataBusOe <= drive_reg && selected && !wordAccepted;
			dataBus <= (drive_reg && selected) ? bufWord : 16'h0000;
		end
	end
endmodule : iiwh_unit
`default_nettype wire

//--- testbench/iiwh_checker.sv
// link assertions for the input word handshake
`timescale 1ns/1ns
`default_nettype none
module iiwh_checker (
	input wire logic ref_clk, // clock
	input wire logic reset_n, // sync reset
	input wire logic xferEnable, // enable
	input wire logic inputDir, // input level
	input wire logic waitFlag, // wait mode
	input wire logic [5:0] unitNum, // unit
	input wire logic instrSync, // sync level
	input wire logic timePulse, // T2/T8
	input wire logic wordAccepted, // accepted
	input wire logic testReturn, // ready reply
	input wire logic syncReturn, // sync reply
	input wire logic [15:0] dataBus, // word
	input wire logic dataBusOe // drive
);
	int unsigned enCnt;
	// span length counter, too long for a repetition
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !xferEnable) begin
			enCnt <= 0;
		end else begin
			enCnt <= enCnt + 1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	AST_DIR_WITH_EN: assert property (inputDir == xferEnable)
		else $error("direction level differs from enable");
	AST_FIELDS_HELD: assert property (xferEnable && $past(xferEnable) |->
		$stable(waitFlag) && $stable(unitNum)) else $error("fields moved");
	AST_SYNC_AT_T4: assert property ($rose(xferEnable) |-> ##[79:83] $rose(instrSync))
		else $error("sync not at T4");
	AST_REPLY_ON_PULSE: assert property ($rose(syncReturn) |->
		$past(timePulse) && $past(instrSync)) else $error("reply without pulse");
	AST_WAIT_NEEDS_READY: assert property (waitFlag && $rose(syncReturn) |-> testReturn)
		else $error("wait reply without ready");
	AST_SKIP_REPLY: assert property (!waitFlag && instrSync && timePulse && !wordAccepted
		&& !syncReturn |-> ##[1:2] syncReturn) else $error("skip reply missing");
	AST_DROP_ON_SYNC_FALL: assert property ($fell(instrSync) |->
		##[1:3] !syncReturn && !testReturn) else $error("replies stuck");
	AST_DRIVE_CLEARED: assert property (wordAccepted |-> ##[1:3] !dataBusOe)
		else $error("drive not cleared");
	AST_DRIVE_GATED: assert property (dataBusOe |-> testReturn && xferEnable)
		else $error("bus driven outside transfer");
	AST_MIN_LENGTH: assert property ($fell(xferEnable) |-> enCnt >= 650)
		else $error("instruction too short");
	COV_TRANSFER: cover property ($rose(dataBusOe));
	COV_SKIP_MISS: cover property ($rose(syncReturn) && !testReturn);
	COV_WAIT: cover property (waitFlag && $rose(testReturn));
endmodule : iiwh_checker
`default_nettype wire

//--- testbench/io_input_word_handshake_tb_top.sv
// bench joining mainframe and unit ends
`timescale 1ns/1ns
`default_nettype none
`include "iiwh_params.svh"
module io_input_word_handshake_tb_top;
	localparam logic [5:0] UNIT = 6'h2A;
	logic ref_clk = 0, reset_n = 0, start = 0, isMemForm = 0, intReq = 0, bufReady = 0;
	logic [15:0] instrWord = 16'h0, pcIn = 16'h0, memRdata = 16'h0, accIn = 16'h0;
	logic [15:0] bufWord = 16'h0, memWdata, accOut, pcOut, unitData, accV, memD;
	logic memWr, accWr, done, skipped, intAccept, xfeN, inN, sawAcc, sawInt;
	logic pfReq = 0, memRd, wordTaken, sawTak;
	logic [15:0] memRdAddr, rdA;
	logic [14:0] memWrAddr, memA;
	int n_fail = 0, samples_checked = 0, k;
	iiwh_if bus();
	always #4 ref_clk = ~ref_clk;
	assign bus.xferEnable = ~xfeN;
	assign bus.inputDir = ~inN;
	// released bus floats to the pull-up level
	assign bus.dataBus = bus.dataBusOe ? unitData : 16'hFFFF;
	iiwh_computer i_iiwh_computer (.ref_clk(ref_clk), .reset_n(reset_n), .start(start),
		.isMemForm(isMemForm), .instrWord(instrWord), .pcIn(pcIn), .memRdata(memRdata),
		.accIn(accIn), .intReq(intReq), .pfIntReq(pfReq), .memRd(memRd), .memRdAddr(memRdAddr),
		.memWr(memWr), .memWrAddr(memWrAddr), .memWdata(memWdata), .accWr(accWr),
		.accOut(accOut), .pcOut(pcOut), .done(done), .skipped(skipped),
		.intAccept(intAccept), .xferEnable_n(xfeN), .inputDir_n(inN),
		.waitFlag(bus.waitFlag), .unitNum(bus.unitNum), .instrSync(bus.instrSync),
		.timePulse(bus.timePulse), .wordAccepted(bus.wordAccepted),
		.testReturn(bus.testReturn), .syncReturn(bus.syncReturn), .dataBus(bus.dataBus));
	iiwh_unit i_iiwh_unit (.ref_clk(ref_clk), .reset_n(reset_n), .myCode(UNIT),
		.bufReady(bufReady), .bufWord(bufWord), .wordTaken(wordTaken), .xferEnable_n(xfeN),
		.inputDir_n(inN), .waitFlag(bus.waitFlag), .unitNum(bus.unitNum),
		.instrSync(bus.instrSync), .timePulse(bus.timePulse),
		.wordAccepted(bus.wordAccepted), .testReturn(bus.testReturn),
		.syncReturn(bus.syncReturn), .dataBus(unitData), .dataBusOe(bus.dataBusOe));
	iiwh_checker i_iiwh_checker (.ref_clk(ref_clk), .reset_n(reset_n),
		.xferEnable(bus.xferEnable), .inputDir(bus.inputDir), .waitFlag(bus.waitFlag),
		.unitNum(bus.unitNum), .instrSync(bus.instrSync), .timePulse(bus.timePulse),
		.wordAccepted(bus.wordAccepted), .testReturn(bus.testReturn),
		.syncReturn(bus.syncReturn), .dataBus(bus.dataBus), .dataBusOe(bus.dataBusOe));
	task automatic check(input string name, input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check
	function automatic logic [15:0] iw(input logic w, m, ind, map);
		iw = 16'h0000;
		iw[`IIWH_WAIT_BIT] = w;
		iw[`IIWH_MERGE_BIT] = m;
		iw[`IIWH_IND_BIT] = ind;
		iw[`IIWH_MAP_BIT] = map;
		iw[`IIWH_UNIT_MSB:`IIWH_UNIT_LSB] = UNIT;
	endfunction : iw
	// one instruction, pulses caught as they pass
	task automatic run(input logic mem, input logic [15:0] w, pc);
		sawAcc = 0;
		sawInt = 0;
		sawTak = 0;
		k = 0;
		@(posedge ref_clk);
		start <= 1'b1;
		isMemForm <= mem;
		instrWord <= w;
		pcIn <= pc;
		@(posedge ref_clk);
		start <= 1'b0;
		do begin
			@(posedge ref_clk);
			#1;
			k++;
			if (accWr === 1'b1) begin
				sawAcc = 1;
				accV = accOut;
			end
			if (memWr === 1'b1) begin
				memA = memWrAddr;
				memD = memWdata;
			end
			if (memRd === 1'b1) rdA = memRdAddr;
			if (wordTaken === 1'b1) sawTak = 1;
			// power fail requests may be taken; only ordinary ones are counted
			if (intAccept === 1'b1 && done !== 1'b1 && pfReq !== 1'b1) sawInt = 1;
		end while (done !== 1'b1 && k < 4000);
		check("three cycles", {15'h0, k >= 650 && k < 4000}, 16'h0001);
	endtask : run
	task automatic sc_acc_ready;
		bufReady <= 1'b1;
		bufWord <= 16'hA55A;
		accIn <= 16'h1234;
		run(1'b0, iw(0, 0, 0, 0), 16'h0100);
		check("accOut", accV, 16'hA55A);
		check("pcOut", pcOut, 16'h0102);
		check("skipped", {15'h0, skipped}, 16'h0001);
		check("word taken", {15'h0, sawTak}, 16'h0001);
	endtask : sc_acc_ready
	task automatic sc_merge;
		bufWord <= 16'hABCD;
		run(1'b0, iw(0, 1, 0, 0), 16'h0200);
		check("merged", accV, 16'hDF34);
	endtask : sc_merge
	task automatic sc_skip_miss;
		bufReady <= 1'b0;
		run(1'b0, iw(0, 0, 0, 0), 16'h0300);
		check("pcOut", pcOut, 16'h0301);
		check("no load", {15'h0, sawAcc}, 16'h0000);
		check("skipped", {15'h0, skipped}, 16'h0000);
		check("word taken", {15'h0, sawTak}, 16'h0000);
	endtask : sc_skip_miss
	// stall in wait mode with an ordinary interrupt pending
	task automatic sc_wait;
		bufWord <= 16'h0F0F;
		intReq <= 1'b1;
		fork
			begin
				repeat (600) @(posedge ref_clk);
				pfReq <= 1'b1;
				repeat (2) @(posedge ref_clk);
				#1;
				check("power fail taken", {15'h0, intAccept}, 16'h0001);
				repeat (298) @(posedge ref_clk);
				bufReady <= 1'b1;
			end
		join_none
		run(1'b0, iw(1, 0, 0, 0), 16'h0400);
		intReq <= 1'b0;
		pfReq <= 1'b0;
		check("stalled", {15'h0, k > 900}, 16'h0001);
		check("accOut", accV, 16'h0F0F);
		check("no interrupt", {15'h0, sawInt}, 16'h0000);
	endtask : sc_wait
	task automatic sc_mem(input logic ind, map, input logic [15:0] rd, input logic [14:0] ea);
		bufReady <= 1'b1;
		bufWord <= 16'h5AA5;
		memRdata <= rd;
		run(1'b1, iw(0, 0, ind, map), 16'h8010);
		check("memWrAddr", {1'b0, memA}, {1'b0, ea});
		check("memWdata", memD, 16'h5AA5);
		check("memRdAddr", rdA, 16'h8011);
		check("pcOut", pcOut, 16'h8013);
	endtask : sc_mem
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		sc_acc_ready();
		sc_merge();
		sc_skip_miss();
		sc_wait();
		sc_mem(1'b0, 1'b0, 16'h0123, 15'h0123);
		sc_mem(1'b1, 1'b0, 16'h1234, 15'h048D);
		sc_mem(1'b1, 1'b1, 16'h1234, 15'h448D);
		print_verdict();
	end
endmodule : io_input_word_handshake_tb_top
`default_nettype wire
